// ===== hdl/rtv_pkg.sv
package rtv_pkg;

	// byte offsets on the register bus
	localparam logic [3:0] RTV_OFS_CTRL = 4'h0;
	localparam logic [3:0] RTV_OFS_WINDOW = 4'h4;
	localparam logic [3:0] RTV_OFS_WDH_VIEW = 4'h8;
	localparam logic [3:0] RTV_OFS_MS_VIEW = 4'hC;

	// value pointer codes
	localparam logic [1:0] RTV_PTR_MS = 2'h0;
	localparam logic [1:0] RTV_PTR_WDH = 2'h1;

	// control register fields
	localparam int RTV_CTRL_WREN_BIT = 0;
	localparam int RTV_CTRL_PTR_LSB = 8;
	localparam int RTV_CTRL_REJ_BIT = 16;
	localparam int RTV_CTRL_WDH_OK_BIT = 17;
	localparam int RTV_CTRL_MS_OK_BIT = 18;

	// weekday/hours digit positions
	localparam int RTV_WEEKDAY_LSB = 8;
	localparam int RTV_HOUR_TENS_LSB = 4;
	localparam int RTV_HOUR_UNITS_LSB = 0;
	// minutes/seconds digit positions
	localparam int RTV_MIN_TENS_LSB = 12;
	localparam int RTV_MIN_UNITS_LSB = 8;
	localparam int RTV_SEC_TENS_LSB = 4;
	localparam int RTV_SEC_UNITS_LSB = 0;

	// implemented bits of each value register
	localparam logic [15:0] RTV_WDH_MASK = 16'h073F;
	localparam logic [15:0] RTV_MS_MASK = 16'h7F7F;

	// values after reset
	localparam logic [15:0] RTV_WDH_RST = 16'h0000;
	localparam logic [15:0] RTV_MS_RST = 16'h0000;
	localparam logic [1:0] RTV_PTR_RST = 2'h0;
	localparam logic [31:0] RTV_RDATA_RST = 32'h0000_0000;

	typedef enum logic [1:0] {
		RTV_BUS_IDLE = 2'b01,
		RTV_BUS_ACK = 2'b10
	} rtv_bus_state_t;

	// byte-lane merge, unimplemented bits forced to zero
	function automatic logic [15:0] rtv_merge16(input logic [15:0] old, input logic [15:0] wdata,
			input logic [1:0] be, input logic [15:0] mask);
		logic [15:0] m;
		m = old;
		if (be[0]) begin
			m[7:0] = wdata[7:0];
		end
		if (be[1]) begin
			m[15:8] = wdata[15:8];
		end
		return m & mask;
	endfunction

	function automatic logic rtv_wdh_ok(input logic [15:0] v);
		return (v[RTV_WEEKDAY_LSB +: 3] <= 3'h6) && (v[RTV_HOUR_TENS_LSB +: 2] <= 2'h2) &&
			(v[RTV_HOUR_UNITS_LSB +: 4] <= 4'h9);
	endfunction

	function automatic logic rtv_ms_ok(input logic [15:0] v);
		return (v[RTV_MIN_TENS_LSB +: 3] <= 3'h5) && (v[RTV_MIN_UNITS_LSB +: 4] <= 4'h9) &&
			(v[RTV_SEC_TENS_LSB +: 3] <= 3'h5) && (v[RTV_SEC_UNITS_LSB +: 4] <= 4'h9);
	endfunction

endpackage

// ===== hdl/rtv_store_if.sv
interface rtv_store_if;
	logic wr_wdh;
	logic wr_ms;
	logic [15:0] wdata;
	logic [1:0] be;
	logic upd_valid;
	logic [15:0] upd_wdh;
	logic [15:0] upd_ms;
	logic [15:0] wdh;
	logic [15:0] ms;

	modport ctrl (output wr_wdh, output wr_ms, output wdata, output be, output upd_valid,
		output upd_wdh, output upd_ms, input wdh, input ms);
	modport store (input wr_wdh, input wr_ms, input wdata, input be, input upd_valid,
		input upd_wdh, input upd_ms, output wdh, output ms);
endinterface

// ===== hdl/rtv_time_regs.sv
// Contract
// - Pointer code 01 maps the value window onto the weekday/hours register.
// - Pointer code 00 maps the value window onto the minutes/seconds register.
// - Hour tens digit sits in bits 5:4 of weekday/hours, BCD 0 to 2.
// - Hour units digit sits in bits 3:0 of weekday/hours, BCD 0 to 9.
// - Minute tens digit sits in bits 14:12 of minutes/seconds, BCD 0 to 5.
// - Minute units digit sits in bits 11:8 of minutes/seconds, BCD 0 to 9.
// - Second tens digit sits in bits 6:4 of minutes/seconds, BCD 0 to 5.
// - Second units digit sits in bits 3:0 of minutes/seconds, BCD 0 to 9.
// - Window writes are dropped unless the time write enable bit is 1.
// - Unused bits of both value registers read zero and store nothing.
module rtv_time_regs (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_upd_valid,
	input wire logic [15:0] i_upd_weekday_hours,
	input wire logic [15:0] i_upd_minutes_seconds,
	output logic [15:0] o_weekday_hours,
	output logic [15:0] o_minutes_seconds,
	output logic o_time_write_enable,
	output logic [1:0] o_value_pointer_select
);

	rtv_store_if st_if ();

	rtv_value_store u_store (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.st(st_if.store)
	);

	rtv_pkg::rtv_bus_state_t state_reg;
	rtv_pkg::rtv_bus_state_t state_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic wren_reg;
	logic wren_next;
	logic [1:0] ptr_reg;
	logic [1:0] ptr_next;
	logic rej_reg;
	logic rej_next;

	logic req;
	logic take;
	logic win_wr;
	logic ctrl_wr;
	logic [15:0] win_val;
	logic [31:0] ctrl_val;

	assign req = i_avs_read | i_avs_write;
	// one wait cycle: read data are registered before waitrequest drops
	assign take = (state_reg == rtv_pkg::RTV_BUS_ACK);
	assign o_avs_waitrequest = req & ~take;
	assign o_avs_readdata = rdata_reg;

	assign win_wr = take & i_avs_write & (i_avs_address[3:2] == rtv_pkg::RTV_OFS_WINDOW[3:2]);
	assign ctrl_wr = take & i_avs_write & (i_avs_address[3:2] == rtv_pkg::RTV_OFS_CTRL[3:2]);

	// pointer codes 10 and 11 select registers outside this block: read zero
	always_comb begin
		win_val = 16'h0000;
		unique case (ptr_reg)
			rtv_pkg::RTV_PTR_WDH: win_val = st_if.wdh;
			rtv_pkg::RTV_PTR_MS: win_val = st_if.ms;
			default: win_val = 16'h0000;
		endcase
	end

	always_comb begin
		ctrl_val = 32'h0000_0000;
		ctrl_val[rtv_pkg::RTV_CTRL_WREN_BIT] = wren_reg;
		ctrl_val[rtv_pkg::RTV_CTRL_PTR_LSB +: 2] = ptr_reg;
		ctrl_val[rtv_pkg::RTV_CTRL_REJ_BIT] = rej_reg;
		ctrl_val[rtv_pkg::RTV_CTRL_WDH_OK_BIT] = rtv_pkg::rtv_wdh_ok(st_if.wdh);
		ctrl_val[rtv_pkg::RTV_CTRL_MS_OK_BIT] = rtv_pkg::rtv_ms_ok(st_if.ms);
	end

	// bus handshake and read data
	always_comb begin
		state_next = state_reg;
		rdata_next = rdata_reg;
		unique case (state_reg)
			rtv_pkg::RTV_BUS_IDLE: begin
				if (req) begin
					state_next = rtv_pkg::RTV_BUS_ACK;
					rdata_next = 32'h0000_0000;
					if (i_avs_read) begin
						unique case (i_avs_address[3:2])
							rtv_pkg::RTV_OFS_CTRL[3:2]: rdata_next = ctrl_val;
							rtv_pkg::RTV_OFS_WINDOW[3:2]: rdata_next = {16'h0000, win_val};
							rtv_pkg::RTV_OFS_WDH_VIEW[3:2]: rdata_next = {16'h0000, st_if.wdh};
							rtv_pkg::RTV_OFS_MS_VIEW[3:2]: rdata_next = {16'h0000, st_if.ms};
						endcase
					end
				end
			end
			rtv_pkg::RTV_BUS_ACK: begin
				state_next = rtv_pkg::RTV_BUS_IDLE;
			end
		endcase
	end

	// control bits; a blocked window write sets the sticky flag, set beats clear
	always_comb begin
		wren_next = wren_reg;
		ptr_next = ptr_reg;
		rej_next = rej_reg;
		if (ctrl_wr && i_avs_byteenable[0]) begin
			wren_next = i_avs_writedata[rtv_pkg::RTV_CTRL_WREN_BIT];
		end
		if (ctrl_wr && i_avs_byteenable[1]) begin
			ptr_next = i_avs_writedata[rtv_pkg::RTV_CTRL_PTR_LSB +: 2];
		end
		if (ctrl_wr && i_avs_byteenable[2] && i_avs_writedata[rtv_pkg::RTV_CTRL_REJ_BIT]) begin
			rej_next = 1'b0;
		end
		if (win_wr && !wren_reg) begin
			rej_next = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg <= rtv_pkg::RTV_BUS_IDLE;
			rdata_reg <= rtv_pkg::RTV_RDATA_RST;
			wren_reg <= 1'b0;
			ptr_reg <= rtv_pkg::RTV_PTR_RST;
			rej_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			rdata_reg <= rdata_next;
			wren_reg <= wren_next;
			ptr_reg <= ptr_next;
			rej_reg <= rej_next;
		end
	end

	// drive the value store
	assign st_if.wr_wdh = win_wr & wren_reg & (ptr_reg == rtv_pkg::RTV_PTR_WDH);
	assign st_if.wr_ms = win_wr & wren_reg & (ptr_reg == rtv_pkg::RTV_PTR_MS);
	assign st_if.wdata = i_avs_writedata[15:0];
	assign st_if.be = i_avs_byteenable[1:0];
	assign st_if.upd_valid = i_upd_valid;
	assign st_if.upd_wdh = i_upd_weekday_hours;
	assign st_if.upd_ms = i_upd_minutes_seconds;

	assign o_weekday_hours = st_if.wdh;
	assign o_minutes_seconds = st_if.ms;
	assign o_time_write_enable = wren_reg;
	assign o_value_pointer_select = ptr_reg;

endmodule

// ===== hdl/rtv_value_store.sv
module rtv_value_store (
	input wire logic i_clk,
	input wire logic i_rst,
	rtv_store_if.store st
);

	logic [15:0] wdh_reg;
	logic [15:0] wdh_next;
	logic [15:0] ms_reg;
	logic [15:0] ms_next;

	// software write beats the one-second update in the same cycle
	always_comb begin
		wdh_next = wdh_reg;
		ms_next = ms_reg;
		if (st.upd_valid) begin
			wdh_next = st.upd_wdh & rtv_pkg::RTV_WDH_MASK;
			ms_next = st.upd_ms & rtv_pkg::RTV_MS_MASK;
		end
		if (st.wr_wdh) begin
			wdh_next = rtv_pkg::rtv_merge16(wdh_reg, st.wdata, st.be, rtv_pkg::RTV_WDH_MASK);
		end
		if (st.wr_ms) begin
			ms_next = rtv_pkg::rtv_merge16(ms_reg, st.wdata, st.be, rtv_pkg::RTV_MS_MASK);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wdh_reg <= rtv_pkg::RTV_WDH_RST;
			ms_reg <= rtv_pkg::RTV_MS_RST;
		end else begin
			wdh_reg <= wdh_next;
			ms_reg <= ms_next;
		end
	end

	assign st.wdh = wdh_reg;
	assign st.ms = ms_reg;

endmodule

// ===== sim/rtv_time_regs_checker.sv
module rtv_time_regs_checker (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic i_upd_valid,
	input wire logic [15:0] i_upd_weekday_hours,
	input wire logic [15:0] i_upd_minutes_seconds,
	input wire logic [15:0] o_weekday_hours,
	input wire logic [15:0] o_minutes_seconds,
	input wire logic o_time_write_enable,
	input wire logic [1:0] o_value_pointer_select
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// update pulses excluded: they may legally load the same edge
	sequence win_wr;
		i_avs_write && !o_avs_waitrequest && i_avs_address[3:2] == 2'h1 && !i_upd_valid;
	endsequence
	sequence win_rd;
		i_avs_read && !o_avs_waitrequest && i_avs_address[3:2] == 2'h1;
	endsequence
	one_wait_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("bus access not answered after one wait cycle");
	wren_gate_a: assert property (win_wr ##0 !o_time_write_enable |=> $stable(o_weekday_hours) && $stable(o_minutes_seconds))
		else $error("window write stored while write enable low");
	wdh_read_a: assert property (win_rd ##0 o_value_pointer_select == 2'h1 |-> o_avs_readdata == {16'h0000, $past(o_weekday_hours)})
		else $error("pointer 01 window read not weekday hours");
	ms_read_a: assert property (win_rd ##0 o_value_pointer_select == 2'h0 |-> o_avs_readdata == {16'h0000, $past(o_minutes_seconds)})
		else $error("pointer 00 window read not minutes seconds");
	wdh_write_a: assert property (win_wr ##0 o_time_write_enable && o_value_pointer_select == 2'h1 && i_avs_byteenable[1:0] == 2'h3
		|=> o_weekday_hours == ($past(i_avs_writedata[15:0]) & 16'h073F))
		else $error("weekday hours write stored wrong bits");
	ms_write_a: assert property (win_wr ##0 o_time_write_enable && o_value_pointer_select == 2'h0 && i_avs_byteenable[1:0] == 2'h3
		|=> o_minutes_seconds == ($past(i_avs_writedata[15:0]) & 16'h7F7F))
		else $error("minutes seconds write stored wrong bits");
	wdh_unused_a: assert property ((o_weekday_hours & 16'hF8C0) == 16'h0000)
		else $error("weekday hours unused bit set");
	ms_unused_a: assert property ((o_minutes_seconds & 16'h8080) == 16'h0000)
		else $error("minutes seconds unused bit set");
endmodule

bind rtv_time_regs rtv_time_regs_checker i_rtv_time_regs_checker (.*);

// ===== sim/rtv_time_regs_tb.sv
module rtv_time_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 1'h0;
	logic i_rst = 1'h1;
	logic [3:0] i_avs_address = 4'h0;
	logic i_avs_read = 1'h0;
	logic i_avs_write = 1'h0;
	logic [31:0] i_avs_writedata = 32'h0000_0000;
	logic [3:0] i_avs_byteenable = 4'h0;
	logic i_upd_valid = 1'h0;
	logic [15:0] i_upd_weekday_hours = 16'h0000;
	logic [15:0] i_upd_minutes_seconds = 16'h0000;
	logic [31:0] o_avs_readdata;
	logic o_avs_waitrequest;
	logic [15:0] o_weekday_hours;
	logic [15:0] o_minutes_seconds;
	logic o_time_write_enable;
	logic [1:0] o_value_pointer_select;
	logic [31:0] rd;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	rtv_time_regs i_rtv_time_regs (.*);
	always #2.5 i_clk = ~i_clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// one idle edge first, so no signal is driven twice in a time step
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge i_clk);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_byteenable <= be;
		i_avs_write <= wr;
		i_avs_read <= !wr;
		// waitrequest and read data seen as the slave samples them at this rising edge
		do @(posedge i_clk); while (o_avs_waitrequest !== 1'h0);
		rd = o_avs_readdata;
		i_avs_write <= 1'h0;
		i_avs_read <= 1'h0;
	endtask
	task automatic t_upd();
		@(posedge i_clk);
		i_upd_weekday_hours <= 16'hFFFF;
		i_upd_minutes_seconds <= 16'h1234;
		i_upd_valid <= 1'h1;
		@(posedge i_clk);
		i_upd_valid <= 1'h0;
		@(negedge i_clk);
		check({16'h0000, o_weekday_hours}, 32'h0000_073F);
		check({16'h0000, o_minutes_seconds}, 32'h0000_1234);
	endtask
	task automatic unused_bus_tail();
		rd = o_avs_readdata;
		@(posedge i_clk);
		i_avs_write <= 1'h0;
		i_avs_read <= 1'h0;
	endtask
	task automatic t_refuse();
		bus(1'h0, 4'h0, 32'h0000_0000, 4'hF);
		check(rd, 32'h0006_0000);
		bus(1'h1, 4'h4, 32'h0000_1234, 4'h3);
		bus(1'h0, 4'hC, 32'h0000_0000, 4'hF);
		check(rd, 32'h0000_0000);
		bus(1'h0, 4'h0, 32'h0000_0000, 4'hF);
		check(rd, 32'h0007_0000);
	endtask
	task automatic t_wdh();
		bus(1'h1, 4'h0, 32'h0001_0101, 4'h7);
		bus(1'h1, 4'h4, 32'hFFFF_FFFF, 4'hF);
		bus(1'h0, 4'h4, 32'h0000_0000, 4'hF);
		check(rd, 32'h0000_073F);
		bus(1'h1, 4'h4, 32'h0000_0623, 4'h3);
		bus(1'h0, 4'h8, 32'h0000_0000, 4'hF);
		check(rd, 32'h0000_0623);
		@(negedge i_clk);
		check({16'h0000, o_minutes_seconds}, 32'h0000_0000);
	endtask
	task automatic t_ms();
		bus(1'h1, 4'h0, 32'h0000_0001, 4'h3);
		bus(1'h1, 4'h4, 32'hFFFF_FFFF, 4'hF);
		bus(1'h0, 4'h4, 32'h0000_0000, 4'hF);
		check(rd, 32'h0000_7F7F);
		bus(1'h1, 4'h4, 32'h0000_5959, 4'h3);
		bus(1'h0, 4'hC, 32'h0000_0000, 4'hF);
		check(rd, 32'h0000_5959);
		bus(1'h1, 4'h4, 32'h0000_0000, 4'h1);
		// the write lands at the ack edge: look once the register has settled
		@(negedge i_clk);
		check({16'h0000, o_minutes_seconds}, 32'h0000_5900);
	endtask
	task automatic t_lock();
		bus(1'h1, 4'h0, 32'h0000_0100, 4'h3);
		bus(1'h1, 4'h4, 32'h0000_0000, 4'h3);
		bus(1'h0, 4'h4, 32'h0000_0000, 4'hF);
		check(rd, 32'h0000_0623);
		check({31'h0000_0000, o_time_write_enable}, 32'h0000_0000);
		check({30'h0000_0000, o_value_pointer_select}, 32'h0000_0001);
	endtask
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			mismatches++;
			report_and_stop();
		end
	end
	initial begin
		repeat (5) @(posedge i_clk);
		i_rst <= 1'h0;
		t_refuse();
		t_wdh();
		t_ms();
		t_lock();
		t_upd();
		report_and_stop();
	end
endmodule
